/* design/dtm_top.sv */
// Top: on-die thermal monitor with APB registers and alarm outputs
`default_nettype none
module dtm_top
   import dtm_pkg::*;
#(
   parameter longint EVAL_COUNT = EVAL_CYCLES  // Cycles per overheat check
)
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,            // Clock enable
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Sensor sample, from the analogue domain
   input  wire logic [8:0]  sensor_temp_i,
   input  wire logic        sensor_valid_i,
   // Alerts
   output logic             irq_o,           // Level, masked status
   output logic             smi_o,           // System mgmt interrupt
   output logic             sci_o,           // ACPI control interrupt
   output logic             s5_req_o,        // Soft-off request, sticky
   // Open-drain overheat pin
   output logic             overheat_alarm_n_o,
   output logic             overheat_alarm_oe_o,
   // Temperature byte to SMBus and eSPI units
   output logic [7:0]       smbus_temp_o,
   output logic [7:0]       espi_temp_o
);
   dtm_trip_if trip_bus ();

   // Synchronisers for the sensor inputs
   logic [8:0] temp_s1;     // First stage
   logic [8:0] temp_s2;     // Second stage
   logic       valid_s1;    // First stage
   logic       valid_s2;    // Second stage
   logic       valid_s3;    // Edge history

   // Registers
   logic [CTRL_W-1:0] ctrl;       // Control bits
   dtm_temp_t         temp_reg;   // Latest reading
   dtm_temp_t         cool_thr;   // Cool trip point
   dtm_temp_t         hot_thr;    // Hot trip point
   dtm_temp_t         hot_limit_value; // Overheat limit
   logic [ST_W-1:0]   status;     // Sticky events
   logic [ST_W-1:0]   mask;       // Interrupt enables
   logic              have_temp;  // A reading exists
   logic [EVAL_W-1:0] eval_cnt;   // One second timer

   // Decodes
   wire        wr_en     = psel_i & penable_i & pwrite_i & pready_o;
   wire        rd_acc    = psel_i & ~penable_i & ~pwrite_i;
   wire        sens_en   = ctrl[CTRL_SENS_EN];
   wire        sample    = valid_s2 & ~valid_s3 & sens_en;
   wire        eval_tick = (eval_cnt == EVAL_W'(EVAL_COUNT - 1));
   wire        addr_ok   = (paddr_i[1:0] == 2'b00)
                           && (paddr_i <= ADDR_REPORT);
   wire        wr_ctrl   = wr_en & (paddr_i == ADDR_CTRL);
   wire        wr_cool   = wr_en & (paddr_i == ADDR_COOL);
   wire        wr_hot    = wr_en & (paddr_i == ADDR_HOT);
   wire        wr_lim    = wr_en & (paddr_i == ADDR_HOTLIM);
   wire        wr_stat   = wr_en & (paddr_i == ADDR_STATUS);
   wire        wr_mask   = wr_en & (paddr_i == ADDR_MASK);
   wire [ST_W-1:0] events;
   wire [7:0]  reply;
   wire        cool_alert;
   wire        hot_alert;
   logic [31:0] next_rdata;

   // Saturate a signed reading into the reply byte
   function automatic logic [7:0] to_byte(input dtm_temp_t t);
      if (t < 0)
         to_byte = REPLY_MIN;
      else if (t > $signed({1'b0, REPLY_MAX}))
         to_byte = REPLY_MAX;
      else
         to_byte = t[7:0];
   endfunction

   // Widen a signed reading to a bus word
   function automatic logic [31:0] sext(input dtm_temp_t t);
      sext = {{(32-TEMP_W){t[TEMP_W-1]}}, t};
   endfunction

   assign trip_bus.sample_stb = sample;
   assign trip_bus.cur        = dtm_temp_t'(temp_s2);
   assign trip_bus.cool_thr   = cool_thr;
   assign trip_bus.hot_thr    = hot_thr;

   // Crossing detection
   dtm_trip u_trip (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .ce_i   (ce_i),
      .en_i   (sens_en),
      .t      (trip_bus)
   );

   // Cool and hot trips raise alerts only when enabled, never in the wrong direction; catastrophic always does
   assign cool_alert = trip_bus.cool_fall & ctrl[CTRL_COOL_EN];
   assign hot_alert  = trip_bus.hot_rise & ctrl[CTRL_HOT_EN];
   assign events     = {trip_bus.cat_hit, hot_alert, cool_alert};

   // Reply byte, 0xFF until a reading exists
   assign reply = (sens_en & have_temp) ? to_byte(temp_reg)
                                         : REPLY_OFF;

   // Read mux; catastrophic level has no address
   always_comb
   begin
      next_rdata = '0;
      unique case (paddr_i)
         ADDR_CTRL:   next_rdata = 32'(ctrl);
         ADDR_TEMP:   next_rdata = sext(temp_reg);
         ADDR_COOL:   next_rdata = sext(cool_thr);
         ADDR_HOT:    next_rdata = sext(hot_thr);
         ADDR_HOTLIM: next_rdata = sext(hot_limit_value);
         ADDR_STATUS: next_rdata = 32'(status);
         ADDR_MASK:   next_rdata = 32'(mask);
         ADDR_REPORT: next_rdata = 32'(reply);
         default:     next_rdata = '0;
      endcase
   end

   // Sensor input synchronisers
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         temp_s1  <= '0;
         temp_s2  <= '0;
         valid_s1 <= 1'b0;
         valid_s2 <= 1'b0;
         valid_s3 <= 1'b0;
      end
      else if (ce_i)
      begin
         temp_s1  <= sensor_temp_i;
         temp_s2  <= temp_s1;
         valid_s1 <= sensor_valid_i;
         valid_s2 <= valid_s1;
         valid_s3 <= valid_s2;
      end
   end

   // APB slave: one wait-free access, read data set in setup
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end
      else if (ce_i)
      begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         if (rd_acc)
            prdata_o <= next_rdata;
      end
   end

   // Programmable registers
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctrl            <= '0;
         cool_thr        <= COOL_RST;
         hot_thr         <= HOT_RST;
         hot_limit_value <= HOTLIM_RST;
         mask            <= '0;
      end
      else if (ce_i)
      begin
         if (wr_ctrl)
            ctrl <= pwdata_i[CTRL_W-1:0];
         // Keep cool below hot below catastrophic
         if (wr_cool && $signed(pwdata_i[TEMP_W-1:0]) < hot_thr)
            cool_thr <= pwdata_i[TEMP_W-1:0];
         if (wr_hot && $signed(pwdata_i[TEMP_W-1:0]) > cool_thr
             && $signed(pwdata_i[TEMP_W-1:0]) < CAT_TRIP)
            hot_thr <= pwdata_i[TEMP_W-1:0];
         if (wr_lim)
            hot_limit_value <= pwdata_i[TEMP_W-1:0];
         if (wr_mask)
            mask <= pwdata_i[ST_W-1:0];
      end
   end

   // Reading capture and sticky status; set beats clear
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         temp_reg  <= '0;
         have_temp <= 1'b0;
         status    <= '0;
      end
      else if (ce_i)
      begin
         if (!sens_en)
            have_temp <= 1'b0;
         else if (sample)
         begin
            temp_reg  <= trip_bus.cur;
            have_temp <= 1'b1;
         end
         status <= (status & ~(wr_stat ? pwdata_i[ST_W-1:0] : '0))
                   | events;
      end
   end

   // Alert outputs and soft-off request
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         irq_o    <= 1'b0;
         smi_o    <= 1'b0;
         sci_o    <= 1'b0;
         s5_req_o <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_o <= |(status & mask);
         smi_o <= (status[ST_COOL] & ~ctrl[CTRL_COOL_SCI])
                | (status[ST_HOT] & ~ctrl[CTRL_HOT_SCI]);
         sci_o <= (status[ST_COOL] & ctrl[CTRL_COOL_SCI])
                | (status[ST_HOT] & ctrl[CTRL_HOT_SCI]);
         if (trip_bus.cat_hit)
            s5_req_o <= 1'b1;
      end
   end

   // Once-per-second overheat evaluation, open-drain drive
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         eval_cnt            <= '0;
         overheat_alarm_n_o  <= 1'b0;
         overheat_alarm_oe_o <= 1'b0;
      end
      else if (ce_i)
      begin
         eval_cnt <= eval_tick ? '0 : eval_cnt + 1'b1;
         if (eval_tick)
            overheat_alarm_oe_o <= sens_en & have_temp
                                   & (temp_reg > hot_limit_value);
      end
   end

   // Temperature byte forwarding to the external links
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         smbus_temp_o <= REPLY_OFF;
         espi_temp_o  <= REPLY_OFF;
      end
      else if (ce_i)
      begin
         smbus_temp_o <= ctrl[CTRL_REPORT_EN] ? reply : REPLY_OFF;
         espi_temp_o  <= ctrl[CTRL_REPORT_EN] ? reply : REPLY_OFF;
      end
   end
endmodule
`default_nettype wire

/* design/dtm_pkg.sv */
// Package: register map, field layout and timing constants of the monitor
`default_nettype none
package dtm_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_TEMP     = 8'h04;
   localparam logic [7:0] ADDR_COOL     = 8'h08;
   localparam logic [7:0] ADDR_HOT      = 8'h0C;
   localparam logic [7:0] ADDR_HOTLIM   = 8'h10;
   localparam logic [7:0] ADDR_STATUS   = 8'h14;
   localparam logic [7:0] ADDR_MASK     = 8'h18;
   localparam logic [7:0] ADDR_REPORT   = 8'h1C;
   // Control register bit positions
   localparam int CTRL_SENS_EN   = 0;
   localparam int CTRL_REPORT_EN = 1;
   localparam int CTRL_COOL_EN   = 2;
   localparam int CTRL_COOL_SCI  = 3;
   localparam int CTRL_HOT_EN    = 4;
   localparam int CTRL_HOT_SCI   = 5;
   localparam int CTRL_W         = 6;
   // Status bit positions
   localparam int ST_COOL  = 0;
   localparam int ST_HOT   = 1;
   localparam int ST_CAT   = 2;
   localparam int ST_W     = 3;
   // Temperature field width
   localparam int TEMP_W = 9;
   typedef logic signed [TEMP_W-1:0] dtm_temp_t;
   // Reset values of the programmable thresholds
   localparam dtm_temp_t COOL_RST   = 9'sh032;
   localparam dtm_temp_t HOT_RST    = 9'sh05A;
   localparam dtm_temp_t HOTLIM_RST = 9'sh064;
   // Fixed catastrophic trip, not reachable from software
   localparam dtm_temp_t CAT_TRIP   = 9'sh06E;
   // Reply byte limits
   localparam logic [7:0] REPLY_OFF = 8'hFF;
   localparam logic [7:0] REPLY_MAX = 8'h7F;
   localparam logic [7:0] REPLY_MIN = 8'h00;
   // Overheat evaluation interval
   localparam longint CLK_HZ      = 50000000;
   localparam longint EVAL_MS     = 1000;
   localparam longint EVAL_CYCLES = (CLK_HZ * EVAL_MS) / 1000;
   localparam int     EVAL_W      = 26;
endpackage
`default_nettype wire

/* design/dtm_trip_if.sv */
// Interface: comparator results passed from trip logic to the top
`default_nettype none
interface dtm_trip_if;
   import dtm_pkg::*;
   logic      sample_stb;   // New sample taken
   dtm_temp_t cur;          // Present sample
   dtm_temp_t cool_thr;     // Cool trip point
   dtm_temp_t hot_thr;      // Hot trip point
   logic      cool_fall;    // Fell through cool
   logic      hot_rise;     // Rose through hot
   logic      cat_hit;      // Reached catastrophic
   modport top  (output sample_stb, cur, cool_thr, hot_thr,
                 input cool_fall, hot_rise, cat_hit);
   modport trip (input sample_stb, cur, cool_thr, hot_thr,
                 output cool_fall, hot_rise, cat_hit);
endinterface
`default_nettype wire

/* design/dtm_trip.sv */
// Crossing detector: compares each sample with the previous one
`default_nettype none
module dtm_trip
   import dtm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic ce_i,
   input  wire logic en_i,
   dtm_trip_if.trip  t
);
   dtm_temp_t prev;        // Previous sample
   logic      prev_valid;  // Previous sample exists

   // Edges need two samples, the first only arms them; catastrophic needs one sample
   assign t.cool_fall = t.sample_stb & prev_valid
                        & (prev >= t.cool_thr) & (t.cur < t.cool_thr);
   assign t.hot_rise  = t.sample_stb & prev_valid
                        & (prev <= t.hot_thr) & (t.cur > t.hot_thr);
   assign t.cat_hit   = t.sample_stb & (t.cur >= CAT_TRIP);

   // History of the last sample
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         prev       <= '0;
         prev_valid <= 1'b0;
      end
      else if (ce_i)
      begin
         if (!en_i)
            prev_valid <= 1'b0;
         else if (t.sample_stb)
         begin
            prev       <= t.cur;
            prev_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* verification/dtm_chk.sv */
// Checker: port-level properties of the thermal monitor
`default_nettype none
module dtm_chk
#(
   parameter longint EVAL_COUNT = 20  // Cycles per overheat check
)
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic       psel_i,
   input  wire logic       penable_i,
   input  wire logic       pready_o,
   input  wire logic       pslverr_o,
   input  wire logic       s5_req_o,
   input  wire logic       overheat_alarm_n_o,
   input  wire logic       overheat_alarm_oe_o,
   input  wire logic [7:0] smbus_temp_o,
   input  wire logic [7:0] espi_temp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   longint gap;  // Cycles since the overheat enable last moved
   // Gap counter, starts full so the first tick is allowed
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         gap <= EVAL_COUNT;
      else
         gap <= $changed(overheat_alarm_oe_o) ? 64'sd1 : gap + 1;
   a_od_data_low: assert property (overheat_alarm_n_o == 1'b0)
      else $error("overheat pin data not low");
   a_s5_sticky: assert property (s5_req_o |=> s5_req_o)
      else $error("soft-off request dropped");
   a_links_same: assert property (smbus_temp_o == espi_temp_o)
      else $error("link bytes differ");
   a_byte_range: assert property (smbus_temp_o <= 8'h7F ||
      smbus_temp_o == 8'hFF) else $error("reply byte out of range");
   a_oe_spacing: assert property ($changed(overheat_alarm_oe_o)
      |-> gap >= EVAL_COUNT) else $error("overheat moved off tick");
   a_pready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_err_with_rdy: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   a_rdy_after_setup: assert property (pready_o |->
      $past(psel_i && !penable_i)) else $error("pready without setup");
endmodule
`default_nettype wire

/* verification/dtm_ec_model.sv */
// Partner model: embedded controller fetching the temperature byte
`default_nettype none
module dtm_ec_model
(
   input  wire logic       clk_i,
   input  wire logic       req_i,     // One-byte read request
   input  wire logic       espi_i,    // High: eSPI, low: SMBus
   input  wire logic [7:0] smbus_i,   // Byte from SMBus unit
   input  wire logic [7:0] espi_b_i,  // Byte from eSPI unit
   output logic      [7:0] byte_o     // Reply taken
);
   timeunit 1ns;
   timeprecision 1ps;
   // One byte from the chosen link per request
   always_ff @(posedge clk_i)
      if (req_i)
         byte_o <= espi_i ? espi_b_i : smbus_i;
endmodule
`default_nettype wire

/* verification/tb.sv */
// Testbench: register and pin tests of the thermal monitor
`default_nettype none
module tb;
   import dtm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EVN = 20;          // Short overheat interval
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        ce_i = 1'b1;        // Clock enable to the design
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [8:0]  sensor_temp_i = 9'h000;
   logic        sensor_valid_i = 1'b0;
   logic        ec_req = 1'b0;      // Controller request
   logic        ec_via = 1'b0;      // Controller link choice
   logic [31:0] prdata_o, q;
   logic        pready_o, pslverr_o, serr, irq_o, smi_o, sci_o;
   logic        s5_req_o, overheat_alarm_n_o, overheat_alarm_oe_o;
   logic [7:0]  smbus_temp_o, espi_temp_o, ec_byte;
   int          failures = 0;
   int          n_compared = 0;
   dtm_top #(.EVAL_COUNT(EVN)) u_dut
   (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .sensor_temp_i(sensor_temp_i),
      .sensor_valid_i(sensor_valid_i), .irq_o(irq_o), .smi_o(smi_o),
      .sci_o(sci_o), .s5_req_o(s5_req_o),
      .overheat_alarm_n_o(overheat_alarm_n_o),
      .overheat_alarm_oe_o(overheat_alarm_oe_o),
      .smbus_temp_o(smbus_temp_o), .espi_temp_o(espi_temp_o)
   );
   dtm_ec_model u_ec
   (
      .clk_i(clk_i), .req_i(ec_req), .espi_i(ec_via),
      .smbus_i(smbus_temp_o), .espi_b_i(espi_temp_o), .byte_o(ec_byte)
   );
   // 50 MHz clock
   always #10 clk_i = ~clk_i;
   // Compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1)
         @(posedge clk_i);
      q = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // Write, then let the outputs settle
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (3) @(posedge clk_i);
   endtask
   // Read and compare
   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask
   // One sensor sample, value steady around the valid edge
   task smp(input logic [8:0] t);
      @(posedge clk_i);
      sensor_temp_i <= t;
      repeat (4) @(posedge clk_i);
      sensor_valid_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      sensor_valid_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   // Controller reads the byte over each link in turn
   task ecr(input logic [7:0] e);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_i);
         ec_via <= v[0];
         ec_req <= 1'b1;
         @(posedge clk_i);
         ec_req <= 1'b0;
         @(posedge clk_i);
         chk("ec_byte", {24'h0, e}, {24'h0, ec_byte});
      end
   endtask
   // Verdict and end of run
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      $display("watchdog expired");
      stop_test;
   end
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      rc("cool", ADDR_COOL, 32'h32);
      rc("hot", ADDR_HOT, 32'h5A);
      rc("hotlim", ADDR_HOTLIM, 32'h64);
      rc("report", ADDR_REPORT, 32'hFF);
      wr(ADDR_HOT, 32'h6E);
      rc("hot_fixed", ADDR_HOT, 32'h5A);
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", 32'h1, {31'h0, serr});
      $display("test reset done");
      wr(ADDR_MASK, 32'h7);
      wr(ADDR_CTRL, 32'h37);
      smp(9'd60);
      rc("temp", ADDR_TEMP, 32'd60);
      rc("status", ADDR_STATUS, 32'h0);
      ecr(8'd60);
      ce_i <= 1'b0;
      smp(9'd70);
      ce_i <= 1'b1;
      rc("frozen", ADDR_TEMP, 32'd60);
      smp(9'd95);
      rc("status", ADDR_STATUS, 32'h2);
      chk("sci", 32'h1, {31'h0, sci_o});
      chk("irq", 32'h1, {31'h0, irq_o});
      wr(ADDR_MASK, 32'h0);
      chk("irq", 32'h0, {31'h0, irq_o});
      wr(ADDR_MASK, 32'h7);
      wr(ADDR_STATUS, 32'h7);
      chk("irq", 32'h0, {31'h0, irq_o});
      smp(9'd85);
      rc("status", ADDR_STATUS, 32'h0);
      smp(9'd40);
      rc("status", ADDR_STATUS, 32'h1);
      chk("smi", 32'h1, {31'h0, smi_o});
      wr(ADDR_STATUS, 32'h7);
      smp(9'd60);
      rc("status", ADDR_STATUS, 32'h0);
      $display("test trips done");
      smp(9'd101);
      repeat (EVN + 2) @(posedge clk_i);
      chk("oe", 32'h1, {31'h0, overheat_alarm_oe_o});
      chk("pin", 32'h0, {31'h0, overheat_alarm_n_o});
      smp(9'd100);
      repeat (EVN + 2) @(posedge clk_i);
      chk("oe", 32'h0, {31'h0, overheat_alarm_oe_o});
      smp(9'h1FB);
      rc("temp", ADDR_TEMP, 32'hFFFFFFFB);
      rc("report", ADDR_REPORT, 32'h0);
      wr(ADDR_HOTLIM, 32'h1F6);
      repeat (EVN + 2) @(posedge clk_i);
      chk("oe", 32'h1, {31'h0, overheat_alarm_oe_o});
      wr(ADDR_STATUS, 32'h7);
      $display("test overheat done");
      chk("s5", 32'h0, {31'h0, s5_req_o});
      smp(9'd110);
      rc("status", ADDR_STATUS, 32'h6);
      chk("s5", 32'h1, {31'h0, s5_req_o});
      smp(9'd200);
      ecr(8'h7F);
      wr(ADDR_CTRL, 32'h36);
      ecr(8'hFF);
      $display("test report done");
      stop_test;
   end
endmodule
bind dtm_top dtm_chk #(.EVAL_COUNT(EVAL_COUNT)) u_chk
(
   .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .s5_req_o(s5_req_o), .overheat_alarm_n_o(overheat_alarm_n_o),
   .overheat_alarm_oe_o(overheat_alarm_oe_o),
   .smbus_temp_o(smbus_temp_o), .espi_temp_o(espi_temp_o)
);
`default_nettype wire
